// >>> sensor_cmd_defines.vh
// Purpose: Constants for the pressure sensor command interpreter.
// Assumes: Included by both design files.
// Notes: Bit positions count from the least significant bit of the command byte.
`ifndef SENSOR_CMD_DEFINES_VH
`define SENSOR_CMD_DEFINES_VH
`define TARGET_ADDR 7'h76
`define CMD_RESET 8'h1e
`define CMD_RESULT_READ 8'h00
`define CMD_CONVERSION_FLAG_BIT_BASE 8'h40
`define CMD_CONVERSION_FLAG_BIT_TEMP_BASE 8'h50
`define CMD_CAL_BASE 8'ha0
`define CONVERSION_FLAG_BIT_FLAG_POS 6
`define TYPE_POS 4
`define RATIO_MAX 3'h5
`define CONVERSION_FLAG_BIT_PREFIX 3'h2
`define CAL_PREFIX 4'ha
`define CAL_WORDS 7
`define CONVERSION_FLAG_BIT_TIME_256_NS 560000
`define CLK_PERIOD_NS 4
`endif

// >>> cal_memory.v
// Purpose: Calibration word storage, reloaded by the reset command.
// Assumes: Contents come from a factory image parameter.
// Notes: Seven 16-bit words held in flip-flops; index 7 reads zero.
`timescale 1ns/1ps
`include "sensor_cmd_defines.vh"
module cal_memory #(
   parameter [111:0] FACTORY_IMAGE = 112'h0
) (
   input wire ref_clk, // System clock.
   input wire rst_n, // Asynchronous reset, active low.
   input wire reload, // Reload pulse from the reset command.
   input wire [2:0] wordIndex, // Selected word.
   output wire [15:0] wordData // Selected word value.
);
   reg [15:0] words_reg [0:7];
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : gWord
         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               words_reg[i] <= 16'h0000;
            end else if (reload) begin
               words_reg[i] <= (i < `CAL_WORDS) ? FACTORY_IMAGE[111-16*i -: 16] : 16'h0000;
            end
         end
      end
   endgenerate
   assign wordData = words_reg[wordIndex];
endmodule // cal_memory

// >>> sensor_cmd_target.v
// Purpose: Two-wire target command interpreter of a pressure sensor.
// Assumes: Bus pins are sampled by ref_clk through two flip-flops.
// Notes: The converter is modelled by a timer and a raw sample input.
// Behaviour
// - Each message framed by start and stop
// - Answers address 1110110, direction bit last
// - One command byte decides everything
// - Reset command accepted anytime, reloads calibration
// - Codes 0x40-0x4A start pressure conversion
// - Codes 0x50-0x5A start temperature conversion
// - Result read returns 24 bits, MSB first
// - Codes 0xA0-0xAE select calibration word
// - Calibration word 16 bits in later read
// - Seven 16-bit calibration words held
// - No fresh conversion or repeat gives zero
// - Read during conversion: zero, result corrupted
// - Conversion during conversion corrupts result
// - Busy until conversion completes, then valid
// - Acknowledge slot after every eight bits
// - Calibration read is command then read
// - Only clock and one shared data line
`timescale 1ns/1ps
`include "sensor_cmd_defines.vh"
module sensor_cmd_target #(
   parameter [111:0] FACTORY_IMAGE = 112'h0,
   parameter integer CONVERSION_FLAG_BIT_TIME_256_NS = `CONVERSION_FLAG_BIT_TIME_256_NS
) (
   input wire ref_clk, // System clock, 250 MHz.
   input wire rst_n, // Asynchronous reset, active low.
   input wire sclIn, // Bus clock pin.
   input wire sdaIn, // Bus data pin level.
   output reg sdaOut, // Data pin drive value, always low.
   output reg sdaOe, // High while pulling data low.
   input wire [23:0] rawSample, // Converter sample, same clock domain.
   output reg convBusy, // Conversion running.
   output reg resultValid // Fresh valid result held.
);
   // ******************************
   // Timing and state codes
   // ******************************
   // Least cycles at the lowest ratio; higher ratios shift left.
   localparam integer BASE_CYCLES = (CONVERSION_FLAG_BIT_TIME_256_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   // Byte engine states.
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_ADDR = 3'h1;
   localparam [2:0] S_CMD = 3'h2;
   localparam [2:0] S_TX = 3'h3;
   localparam [2:0] S_SKIP = 3'h4;
   // What the next read transfer returns.
   localparam [1:0] M_NONE = 2'h0;
   localparam [1:0] M_RESULT = 2'h1;
   localparam [1:0] M_CAL = 2'h2;

   // ******************************
   // Pin synchronisers
   // ******************************
   // The third flop of each pin only serves edge detection.
   reg sclMeta_reg;
   reg sclSync_reg;
   reg sclOld_reg;
   reg sdaMeta_reg;
   reg sdaSync_reg;
   reg sdaOld_reg;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclMeta_reg <= 1'b1;
         sclSync_reg <= 1'b1;
         sclOld_reg <= 1'b1;
         sdaMeta_reg <= 1'b1;
         sdaSync_reg <= 1'b1;
         sdaOld_reg <= 1'b1;
      end else begin
         sclMeta_reg <= sclIn;
         sclSync_reg <= sclMeta_reg;
         sclOld_reg <= sclSync_reg;
         sdaMeta_reg <= sdaIn;
         sdaSync_reg <= sdaMeta_reg;
         sdaOld_reg <= sdaSync_reg;
      end
   end
   wire sclRise = sclSync_reg & ~sclOld_reg;
   wire sclFall = ~sclSync_reg & sclOld_reg;
   wire startCond = sclSync_reg & sclOld_reg & sdaOld_reg & ~sdaSync_reg;
   wire stopCond = sclSync_reg & sclOld_reg & ~sdaOld_reg & sdaSync_reg;

   // ******************************
   // Byte engine
   // ******************************
   reg [2:0] state_reg;
   reg [3:0] bitCnt_reg;
   reg [7:0] shift_reg;
   reg [23:0] txData_reg;
   reg [1:0] mode_reg;
   reg [2:0] calIndex_reg;
   reg [1:0] txBytes_reg;
   reg [23:0] result_reg;
   reg resultCorrupt_reg;
   reg [23:0] convTimer_reg;
   reg convType_reg;
   wire [15:0] calWord;
   wire [7:0] rxByte = shift_reg;
   wire ackSlot = (bitCnt_reg == 4'h8);
   wire byteDone = sclRise & (bitCnt_reg == 4'h7);
   reg reloadPulse;
   wire [7:0] cmdByte = {shift_reg[6:0], sdaSync_reg};

   // ******************************
   // Command decode
   // ******************************
   // The flags look at the byte as it completes, with the eighth bit taken
   // straight from the synchroniser, so they are only meaningful at byteDone.
   wire isReset = (cmdByte == `CMD_RESET);
   wire isRead = (cmdByte == `CMD_RESULT_READ);
   // Conversion codes share one prefix; the ratio field stops at five and
   // the lowest bit must be clear. The type bit splits pressure from temperature.
   wire convPrefix = (cmdByte[7:5] == `CONVERSION_FLAG_BIT_PREFIX);
   wire ratioOk = (cmdByte[3:1] <= `RATIO_MAX);
   wire isConv = convPrefix & ratioOk & ~cmdByte[0];
   // Calibration codes carry the word index in the ratio field.
   wire isCal = (cmdByte[7:4] == `CAL_PREFIX) & ~cmdByte[0];
   wire [2:0] ratioSel = cmdByte[3:1];

   // Pull-low enable for the first bit of a read transfer, before anything is shifted.
   wire calFirst = (mode_reg == M_CAL) & ~calWord[15];
   wire resFirst = (mode_reg == M_RESULT) & resultValid & ~result_reg[23];
   wire zeroFirst = ~((mode_reg == M_CAL) | ((mode_reg == M_RESULT) & resultValid));

   // ******************************
   // Calibration storage
   // ******************************
   cal_memory #(
      .FACTORY_IMAGE(FACTORY_IMAGE)
   ) uCal (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .reload(reloadPulse),
      .wordIndex(calIndex_reg),
      .wordData(calWord)
   );

   // ******************************
   // Converter and byte engine
   // ******************************
   // The conversion type is kept for the converter model; it does not change the timing.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         // All outputs return low so that the data line is released during reset.
         state_reg <= S_IDLE;
         bitCnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         txData_reg <= 24'h000000;
         mode_reg <= M_NONE;
         calIndex_reg <= 3'h0;
         txBytes_reg <= 2'h0;
         result_reg <= 24'h000000;
         resultCorrupt_reg <= 1'b0;
         convTimer_reg <= 24'h000000;
         convType_reg <= 1'b0;
         convBusy <= 1'b0;
         resultValid <= 1'b0;
         sdaOut <= 1'b0;
         sdaOe <= 1'b0;
         reloadPulse <= 1'b0;
      end else begin
         reloadPulse <= 1'b0;
         // Converter model: the timer counts down from the ratio's length and the
         // sample is captured on the last count. A corrupted run stores the
         // inverted sample so that a misused conversion can be told apart.
         if (convBusy) begin
            if (convTimer_reg == 24'h000001) begin
               convBusy <= 1'b0;
               resultValid <= 1'b1;
               result_reg <= resultCorrupt_reg ? ~rawSample : rawSample;
            end
            convTimer_reg <= convTimer_reg - 24'h000001;
         end
         // Stop and start win over whatever the byte engine was doing, so a
         // message cut short always returns the engine to a known state.
         if (stopCond) begin
            state_reg <= S_IDLE;
            sdaOe <= 1'b0;
         end else if (startCond) begin
            state_reg <= S_ADDR;
            bitCnt_reg <= 4'h0;
            sdaOe <= 1'b0;
         end else begin
            case (state_reg)
               S_ADDR, S_CMD: begin
                  if (sclRise && !ackSlot) begin
                     shift_reg <= cmdByte;
                     bitCnt_reg <= bitCnt_reg + 4'h1;
                  end
                  // Acknowledge on the falling edge after the eighth bit; a foreign
                  // address leaves the line alone until the next start or stop.
                  if (sclFall && bitCnt_reg == 4'h8 && !sdaOe) begin
                     if (state_reg == S_ADDR && rxByte[7:1] == `TARGET_ADDR) begin
                        sdaOe <= 1'b1;
                     end else if (state_reg == S_CMD) begin
                        sdaOe <= 1'b1;
                     end else begin
                        state_reg <= S_SKIP;
                     end
                  end else if (sclFall && sdaOe) begin
                     sdaOe <= 1'b0;
                     bitCnt_reg <= 4'h0;
                     if (state_reg == S_CMD) begin
                        state_reg <= S_SKIP;
                     end else if (shift_reg[0]) begin
                        // A read transfer loads the word chosen by the last command and
                        // puts its first bit on the line at once, since the controller
                        // samples it on the next rising edge.
                        state_reg <= S_TX;
                        txBytes_reg <= (mode_reg == M_CAL) ? 2'h2 : 2'h3;
                        if (mode_reg == M_CAL) begin
                           txData_reg <= {calWord, 8'h00};
                        end else if (mode_reg == M_RESULT && resultValid) begin
                           txData_reg <= result_reg;
                           resultValid <= 1'b0;
                        end else begin
                           txData_reg <= 24'h000000;
                        end
                        mode_reg <= M_NONE;
                        sdaOe <= calFirst | resFirst | zeroFirst;
                     end else begin
                        state_reg <= S_CMD;
                     end
                  end
                  // Command decode at the eighth command bit.
                  if (state_reg == S_CMD && byteDone) begin
                     if (isReset) begin
                        // The reset command also aborts a running conversion and
                        // drops any stored result.
                        reloadPulse <= 1'b1;
                        convBusy <= 1'b0;
                        resultValid <= 1'b0;
                        resultCorrupt_reg <= 1'b0;
                        mode_reg <= M_NONE;
                     end else if (isRead) begin
                        mode_reg <= M_RESULT;
                        if (convBusy) resultCorrupt_reg <= 1'b1;
                     end else if (isCal) begin
                        mode_reg <= M_CAL;
                        calIndex_reg <= cmdByte[3:1];
                     end else if (isConv) begin
                        // A second conversion command while busy only marks the run
                        // as corrupted; restarting the timer would hide the misuse.
                        if (convBusy) begin
                           resultCorrupt_reg <= 1'b1;
                        end else begin
                           convBusy <= 1'b1;
                           resultCorrupt_reg <= 1'b0;
                           resultValid <= 1'b0;
                           convType_reg <= cmdByte[`TYPE_POS];
                           convTimer_reg <= BASE_CYCLES[23:0] << ratioSel;
                        end
                     end
                     // Any other code leaves state untouched.
                  end
               end
               S_TX: begin
                  // Bits move out on falling edges; after each byte the line is
                  // released for the controller's acknowledge, and a missing
                  // acknowledge ends the transfer.
                  if (sclFall) begin
                     if (bitCnt_reg < 4'h7) begin
                        txData_reg <= {txData_reg[22:0], 1'b0};
                        sdaOe <= ~txData_reg[22];
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                     end else if (bitCnt_reg == 4'h7) begin
                        sdaOe <= 1'b0;
                        bitCnt_reg <= 4'h8;
                     end else begin
                        bitCnt_reg <= 4'h0;
                        if (txBytes_reg == 2'h1 || shift_reg[0] == 1'b0) begin
                           state_reg <= S_SKIP;
                           sdaOe <= 1'b0;
                        end else begin
                           txData_reg <= {txData_reg[22:0], 1'b0};
                           sdaOe <= ~txData_reg[22];
                        end
                        txBytes_reg <= txBytes_reg - 2'h1;
                     end
                  end
                  // The controller's acknowledge is kept in the low bit of the shift
                  // register, which is free while sending.
                  if (sclRise && bitCnt_reg == 4'h8) begin
                     shift_reg[0] <= ~sdaSync_reg;
                  end
               end
               S_SKIP, S_IDLE: begin
                  sdaOe <= 1'b0;
               end
               default: begin
                  state_reg <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule // sensor_cmd_target

// >>> sensor_cmd_monitor.sv
// Purpose: Port checker for the sensor command target.
// Assumes: Bound to every sensor_cmd_target; counts are ref_clk cycles of 4 ns.
// Notes: The bus clock is sampled as a plain level.
`timescale 1ns/1ps
module sensor_cmd_monitor #(
   parameter integer CONVERSION_FLAG_BIT_TIME_256_NS = 560000
) (
   input wire logic ref_clk, // Clock.
   input wire logic rst_n, // Reset, active low.
   input wire logic sclIn, // Bus clock.
   input wire logic sdaIn, // Data line.
   input wire logic sdaOut, // Data drive value.
   input wire logic sdaOe, // Data pull enable.
   input wire logic [23:0] rawSample, // Converter sample.
   input wire logic convBusy, // Conversion running.
   input wire logic resultValid // Fresh result held.
);
   localparam int MAX_BUSY = CONVERSION_FLAG_BIT_TIME_256_NS * 8 + 16;
   logic [31:0] busyCnt_reg;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) busyCnt_reg <= 32'h0;
      else busyCnt_reg <= convBusy ? busyCnt_reg + 32'h1 : 32'h0;
   end
   a_out_low: assert property (sdaOe |-> sdaOut == 1'b0)
      else $error("data driven high");
   a_oe_clock_low: assert property (($rose(sdaOe) || $fell(sdaOe)) |-> !sclIn)
      else $error("data changed with clock high");
   a_oe_bit_hold: assert property ($rose(sdaOe) |-> sdaOe [*8])
      else $error("driven bit too short");
   a_reset_quiet: assert property ($rose(rst_n) |-> !sdaOe && !convBusy && !resultValid)
      else $error("outputs active after reset");
   a_valid_cause: assert property ($rose(resultValid) |-> $past(convBusy) || $past(convBusy, 2))
      else $error("result without conversion");
   a_busy_no_valid: assert property (convBusy && $past(convBusy) |-> !resultValid)
      else $error("result valid while busy");
   a_busy_min: assert property ($rose(convBusy) |-> convBusy [*8])
      else $error("conversion too short");
   a_busy_bound: assert property (busyCnt_reg <= MAX_BUSY)
      else $error("conversion too long");
endmodule // sensor_cmd_monitor
bind sensor_cmd_target sensor_cmd_monitor #(.CONVERSION_FLAG_BIT_TIME_256_NS(CONVERSION_FLAG_BIT_TIME_256_NS)) mon (
   .ref_clk(ref_clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
   .sdaOe(sdaOe), .rawSample(rawSample), .convBusy(convBusy), .resultValid(resultValid));

// >>> i2c_ctrl_model.sv
// Purpose: Bus controller model that frames and clocks every message.
// Assumes: Data line has a pull-up; a drive of 1 releases it.
// Notes: One bus bit takes 40 ref_clk cycles, 160 ns.
`timescale 1ns/1ps
module i2c_ctrl_model (
   input wire logic ref_clk, // Timing clock.
   input wire logic sdaLine, // Resolved data line.
   output logic scl, // Bus clock, idle high.
   output logic sdaDrive // Controller data drive.
);
   initial begin
      scl = 1'b1;
      sdaDrive = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic sclTo(input logic c, input int n);
      scl <= c;
      wt(n);
   endtask
   task automatic bitOut(input logic b);
      sdaDrive <= b;
      wt(10);
      sclTo(1'b1, 20);
      sclTo(1'b0, 10);
   endtask
   task automatic bitIn(output logic b);
      sdaDrive <= 1'b1;
      wt(10);
      sclTo(1'b1, 10);
      b = sdaLine;
      wt(10);
      sclTo(1'b0, 10);
   endtask
   task automatic start();
      sdaDrive <= 1'b0;
      wt(20);
      sclTo(1'b0, 10);
   endtask
   task automatic stop();
      sdaDrive <= 1'b0;
      wt(10);
      sclTo(1'b1, 20);
      sdaDrive <= 1'b1;
      wt(20);
   endtask
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) bitOut(d[i]);
      bitIn(b);
      ack = ~b;
   endtask
   task automatic writeCmd(input logic [6:0] a, input logic [7:0] c, output logic ok);
      logic a1, a2;
      a2 = 1'b0;
      start();
      sendByte({a, 1'b0}, a1);
      if (a1) sendByte(c, a2);
      stop();
      ok = a1 & a2;
   endtask
   task automatic readBytes(input int n, output logic [23:0] v);
      logic a, b;
      v = 24'h0;
      start();
      sendByte({7'h76, 1'b1}, a);
      for (int k = 0; k < n * 8; k++) begin
         bitIn(b);
         v = {v[22:0], b};
         if (k % 8 == 7) bitOut(k == n * 8 - 1);
      end
      stop();
   endtask
   task automatic stall();
      logic a;
      start();
      sendByte({7'h76, 1'b1}, a);
   endtask
   task automatic recover();
      logic b;
      repeat (9) bitIn(b);
      stop();
   endtask
endmodule // i2c_ctrl_model

// >>> tb.sv
// Purpose: Self-checking bench for the sensor command target.
// Assumes: Conversion base time shortened to 400 ns.
// Notes: A corrupted result is the inverse of the sample.
`timescale 1ns/1ps
module tb;
   localparam integer BASE_NS = 400;
   localparam [111:0] IMAGE = 112'h1a2b_3c4d_5e6f_7081_92a3_b4c5_d6e7;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [23:0] rawSample = 24'h0;
   logic scl, mSda, sdaOut, sdaOe, convBusy, resultValid, ok;
   wire sdaLine = mSda & ~sdaOe;
   logic [23:0] v;
   int n, busyLen = 0, n_fail = 0, tests_run = 0;
   sensor_cmd_target #(.FACTORY_IMAGE(IMAGE), .CONVERSION_FLAG_BIT_TIME_256_NS(BASE_NS)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .rawSample(rawSample), .convBusy(convBusy), .resultValid(resultValid));
   i2c_ctrl_model bus (.ref_clk(ref_clk), .sdaLine(sdaLine), .scl(scl), .sdaDrive(mSda));
   initial forever #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (convBusy === 1'b1) busyLen <= busyLen + 1;
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic waitIdle();
      n = 0;
      while (convBusy !== 1'b0 && n < 20000) begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   task automatic readResult(input logic [23:0] exp);
      bus.writeCmd(7'h76, 8'h00, ok);
      bus.readBytes(3, v);
      chk(v, exp);
   endtask
   task automatic t_cal();
      bus.writeCmd(7'h77, 8'h1e, ok);
      chk(ok, 0);
      bus.writeCmd(7'h76, 8'h1e, ok);
      chk(ok, 1);
      for (int w = 0; w < 8; w++) begin
         bus.writeCmd(7'h76, 8'(32'ha0 + 2 * w), ok);
         bus.readBytes(2, v);
         chk(v, w < 7 ? 24'(IMAGE >> (16 * (6 - w))) & 24'hffff : 24'h0);
      end
   endtask
   task automatic t_conversion_flag_bit();
      int t0;
      for (int k = 0; k < 6; k++) begin
         for (int t = 0; t < 2; t++) begin
            t0 = (BASE_NS << k) / 4;
            rawSample <= 24'h3a5c00 + 24'(k * 16 + t);
            busyLen <= 0;
            bus.writeCmd(7'h76, 8'(64 + 16 * t + 2 * k), ok);
            waitIdle();
            chk(24'(busyLen >= t0 - 2 && busyLen <= t0 + 2), 1);
            chk(resultValid, 1);
            readResult(24'h3a5c00 + 24'(k * 16 + t));
            readResult(24'h0);
         end
      end
   endtask
   task automatic t_misuse();
      rawSample <= 24'h3c5a69;
      bus.writeCmd(7'h76, 8'h4a, ok);
      readResult(24'h0);
      chk(convBusy, 1);
      waitIdle();
      readResult(24'hc3a596);
      bus.writeCmd(7'h76, 8'h4a, ok);
      bus.writeCmd(7'h76, 8'h50, ok);
      waitIdle();
      readResult(24'hc3a596);
      bus.writeCmd(7'h76, 8'h40, ok);
      waitIdle();
      bus.writeCmd(7'h76, 8'h33, ok);
      chk(resultValid, 1);
      readResult(24'h3c5a69);
      bus.writeCmd(7'h76, 8'h5a, ok);
      bus.writeCmd(7'h76, 8'h1e, ok);
      chk({convBusy, resultValid}, 0);
      bus.stall();
      chk(sdaOe, 1);
      bus.recover();
      chk(sdaOe, 0);
      bus.writeCmd(7'h76, 8'h1e, ok);
      chk(ok, 1);
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_cal();
      t_conversion_flag_bit();
      t_misuse();
      give_verdict();
   end
   initial begin
      #600000;
      n_fail++;
      give_verdict();
   end
endmodule // tb
